// File: design/ssfc_top.sv
// Serial slave frame checker: link shift path and frame evaluation
`timescale 1ns/100ps
`default_nettype none
`include "ssfc_defines.svh"
module ssfc_top
  import ssfc_pkg::*;
#(
  parameter int CNT_BITS = `SSFC_CNT_BITS
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic                       serialClk,
  input  wire logic                       selectActiveLow,
  input  wire logic                       serialIn,
  input  wire logic                       sleepMode,
  input  wire logic [`SSFC_WORD_BITS-1:0] respWord,
  output ssfc_cmd_t                       cmd,
  output ssfc_pad_t                       serialOut,
  output logic                            frameErrorFlag,
  output logic                            frameBusy
);

  localparam logic [CNT_BITS-1:0] MIN_BITS =
    CNT_BITS'(`SSFC_MIN_BITS);
  localparam logic [CNT_BITS-1:0] BYTE_MASK =
    CNT_BITS'(`SSFC_BYTE_BITS - 1);
  localparam logic [CNT_BITS-1:0] CNT_MAX = '1;

  // Link domain (serialClk)
  logic                       linkRst_b;
  logic                       startedReg;
  logic                       driveShiftReg;
  logic [CNT_BITS-1:0]        cntReg;
  logic [CNT_BITS-1:0]        effCnt;
  logic [`SSFC_WORD_BITS-1:0] rxShiftReg;
  logic                       txBitReg;
  logic [3:0]                 txIdx;

  // System domain (sys_clk)
  logic                       selSync;
  logic                       selPrevReg;
  logic                       selFall;
  logic                       selRise;
  ssfc_state_t                stateReg;
  logic [`SSFC_WORD_BITS-1:0] txWordReg;
  logic                       errFlagReg;
  logic                       cmdValidReg;
  logic [`SSFC_WORD_BITS-1:0] cmdWordReg;
  logic                       lengthOk;
  logic                       startSync;
  logic                       pulseSeenReg;

  // Length check shared by the evaluation and the assertions
  function automatic logic validLength(input logic [CNT_BITS-1:0] n);
    validLength = (n >= MIN_BITS) && ((n & BYTE_MASK) == '0) &&
                  (n != CNT_MAX);
  endfunction

  // Select high forces the frame flags back without any clock edge
  assign linkRst_b = rst_b & ~selectActiveLow;

  always_ff @(negedge serialClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      startedReg <= 1'b0;
    end else begin
      startedReg <= 1'b1;
    end
  end

  // Counter is not cleared by select, so it stays readable after the frame
  always_ff @(negedge serialClk or negedge rst_b) begin
    if (!rst_b) begin
      cntReg <= '0;
    end else if (!startedReg) begin
      cntReg <= CNT_BITS'(1);
    end else if (cntReg != CNT_MAX) begin
      cntReg <= cntReg + CNT_BITS'(1);
    end
  end

  always_ff @(negedge serialClk or negedge rst_b) begin
    if (!rst_b) begin
      rxShiftReg <= '0;
    end else begin
      // MSB arrives first and ends up at the top
      rxShiftReg <= {rxShiftReg[`SSFC_WORD_BITS-2:0], serialIn};
    end
  end

  assign effCnt = startedReg ? cntReg : '0;
  assign txIdx  = 4'hF - effCnt[3:0];

  always_ff @(posedge serialClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      driveShiftReg <= 1'b0;
    end else begin
      driveShiftReg <= 1'b1;
    end
  end

  always_ff @(posedge serialClk or negedge rst_b) begin
    if (!rst_b) begin
      txBitReg <= 1'b0;
    end else if (effCnt < MIN_BITS) begin
      txBitReg <= txWordReg[txIdx];
    end else begin
      txBitReg <= rxShiftReg[`SSFC_WORD_BITS-1];
    end
  end

  // Before the first rising edge the pin shows error OR input
  assign serialOut.out = driveShiftReg ? txBitReg
                                       : (errFlagReg | serialIn);
  assign serialOut.oeN = selectActiveLow | sleepMode |
                         (stateReg == SSFC_IGNORED);

  // System side: select crosses through two flops
  ssfc_sync2 #(
    .RESET_VAL(1'b1)
  ) u_selSync (
    .clk  (sys_clk),
    .rst_b(rst_b),
    .d    (selectActiveLow),
    .q    (selSync)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      selPrevReg <= 1'b1;
    end else if (ce) begin
      selPrevReg <= selSync;
    end
  end

  assign selFall  = selPrevReg & ~selSync;
  assign selRise  = ~selPrevReg & selSync;
  // Started flag crosses as a level; it stays high from the first falling clock edge until select rises
  ssfc_sync2 #(
    .RESET_VAL(1'b0)
  ) u_startSync (
    .clk  (sys_clk),
    .rst_b(rst_b),
    .d    (startedReg),
    .q    (startSync)
  );

  // A frame without pulses would leave the old count behind and pass
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pulseSeenReg <= 1'b0;
    end else if (ce) begin
      if (selFall) begin
        pulseSeenReg <= 1'b0;
      end else if (startSync && stateReg == SSFC_ACTIVE) begin
        pulseSeenReg <= 1'b1;
      end
    end
  end

  // Link state is quiet here: clock is held low while select is high
  assign lengthOk = pulseSeenReg &&
                    validLength(cntReg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= SSFC_IDLE;
    end else if (ce) begin
      case (stateReg)
        SSFC_IDLE: begin
          if (selFall && sleepMode) begin
            stateReg <= SSFC_IGNORED;
          end else if (selFall) begin
            stateReg <= SSFC_ACTIVE;
          end
        end
        SSFC_ACTIVE, SSFC_IGNORED: begin
          if (selRise) begin
            stateReg <= SSFC_IDLE;
          end
        end
        default: begin
          stateReg <= SSFC_IDLE;
        end
      endcase
    end
  end

  // Response is frozen from select fall on; lead time covers the sync delay
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      txWordReg <= '0;
    end else if (ce && selFall && !sleepMode) begin
      txWordReg <= respWord;
    end
  end

  // A later good frame clears the flag only at its end, so the flag stands
  // on the output through the whole lead time; a bad end sets it again
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      errFlagReg <= `SSFC_ERR_RESET;
    end else if (ce && stateReg == SSFC_ACTIVE && selRise) begin
      if (!lengthOk) begin
        errFlagReg <= 1'b1;
      end else begin
        errFlagReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdValidReg <= 1'b0;
      cmdWordReg  <= '0;
    end else if (ce) begin
      cmdValidReg <= 1'b0;
      if (stateReg == SSFC_ACTIVE && selRise && lengthOk) begin
        cmdValidReg <= 1'b1;
        cmdWordReg  <= rxShiftReg;
      end
    end
  end

  assign cmd.valid      = cmdValidReg;
  assign cmd.word       = cmdWordReg;
  assign frameErrorFlag = errFlagReg;
  assign frameBusy      = (stateReg != SSFC_IDLE);

  // Checks, system clock domain
  property p_err_set;
    @(posedge sys_clk) disable iff (!rst_b)
    ce && stateReg == SSFC_ACTIVE && selRise && !lengthOk |=> errFlagReg;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("error flag not set after bad frame length");

  property p_bad_no_cmd;
    @(posedge sys_clk) disable iff (!rst_b)
    ce && selRise && !lengthOk |=> !cmdValidReg;
  endproperty
  a_bad_no_cmd: assert property (p_bad_no_cmd)
    else $error("command issued for bad frame length");

  property p_cmd_word;
    @(posedge sys_clk) disable iff (!rst_b)
    ce && stateReg == SSFC_ACTIVE && selRise && lengthOk |=>
      cmdValidReg && cmdWordReg == $past(rxShiftReg) ##1 !cmdValidReg;
  endproperty
  a_cmd_word: assert property (p_cmd_word)
    else $error("good frame did not deliver one command pulse");

  property p_length;
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(cmdValidReg) |->
      $past(cntReg) >= MIN_BITS && $past(cntReg[2:0]) == 3'h0;
  endproperty
  a_length: assert property (p_length)
    else $error("command taken with invalid pulse count");

  property p_hiz;
    @(posedge sys_clk) disable iff (!rst_b)
    selectActiveLow |-> serialOut.oeN;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("output driven while select high");

  property p_sleep;
    @(posedge sys_clk) disable iff (!rst_b)
    sleepMode || stateReg == SSFC_IGNORED |-> serialOut.oeN;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("output driven during sleep frame");

  property p_load;
    @(posedge sys_clk) disable iff (!rst_b)
    ce && selFall && !sleepMode |=> txWordReg == $past(respWord);
  endproperty
  a_load: assert property (p_load)
    else $error("response not loaded at select fall");

  property p_err_clear;
    @(posedge sys_clk) disable iff (!rst_b)
    ce && stateReg == SSFC_ACTIVE && selRise && lengthOk
      |=> !errFlagReg;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error flag not cleared after being reported");

  property p_so_or;
    @(posedge sys_clk) disable iff (!rst_b)
    !selectActiveLow && !driveShiftReg |->
      serialOut.out == (errFlagReg | serialIn);
  endproperty
  a_so_or: assert property (p_so_or)
    else $error("first output bit is not error OR input");

  property p_err_hold;
    @(posedge sys_clk) disable iff (!rst_b)
    errFlagReg && !(ce && stateReg == SSFC_ACTIVE && selRise && lengthOk)
      |=> errFlagReg;
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error flag lost before being reported");

  property p_drive;
    @(posedge sys_clk) disable iff (!rst_b)
    !selectActiveLow && !sleepMode && stateReg != SSFC_IGNORED |->
      !serialOut.oeN;
  endproperty
  a_drive: assert property (p_drive)
    else $error("output not driven during selected frame");

  property p_no_pulse;
    @(posedge sys_clk) disable iff (!rst_b)
    ce && stateReg == SSFC_ACTIVE && selRise && !pulseSeenReg |=>
      !cmdValidReg && errFlagReg;
  endproperty
  a_no_pulse: assert property (p_no_pulse)
    else $error("frame without clock pulses was accepted");

  // Checks, link clock domain
  property p_msb_first;
    @(posedge serialClk) disable iff (!linkRst_b)
    !startedReg |=> txBitReg == $past(txWordReg[`SSFC_WORD_BITS-1]);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first shifted bit is not the response MSB");

  property p_pass_through;
    @(posedge serialClk) disable iff (!linkRst_b)
    effCnt >= MIN_BITS |=> txBitReg == $past(rxShiftReg[`SSFC_WORD_BITS-1]);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("bit after the own word did not pass through");

  c_good_frame: cover property (
    @(posedge sys_clk) disable iff (!rst_b) cmdValidReg);
  c_bad_frame: cover property (
    @(posedge sys_clk) disable iff (!rst_b) $rose(errFlagReg));
  c_long_frame: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    cmdValidReg && $past(cntReg) > MIN_BITS);
  c_sleep_frame: cover property (
    @(posedge sys_clk) disable iff (!rst_b) stateReg == SSFC_IGNORED);
  c_no_pulse: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    stateReg == SSFC_ACTIVE && selRise && !pulseSeenReg);

endmodule
`default_nettype wire

// File: design/ssfc_defines.svh
// Constants of the serial slave frame checker
`ifndef SSFC_DEFINES_SVH
`define SSFC_DEFINES_SVH
`define SSFC_WORD_BITS   16
`define SSFC_MIN_BITS    16
`define SSFC_BYTE_BITS   8
`define SSFC_CNT_BITS    8
`define SSFC_ERR_RESET   1'b0
`define SSFC_SYNC_STAGES 2
`endif

// File: design/ssfc_pkg.sv
// Types shared by the serial slave frame checker
`include "ssfc_defines.svh"
package ssfc_pkg;
  typedef enum {SSFC_IDLE, SSFC_ACTIVE, SSFC_IGNORED} ssfc_state_t;
  typedef struct packed {
    logic                       valid;
    logic [`SSFC_WORD_BITS-1:0] word;
  } ssfc_cmd_t;
  typedef struct packed {
    logic out;
    logic oeN;
  } ssfc_pad_t;
endpackage

// File: design/ssfc_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
`default_nettype none
module ssfc_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic d,
  output var  logic q
);
  logic firstReg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      firstReg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      firstReg <= d;
      q        <= firstReg;
    end
  end
endmodule
`default_nettype wire

// File: bench/ssfc_spi_master.sv
// Master model for the serial link of the frame checker
`timescale 1ns/100ps
`default_nettype none
module ssfc_spi_master (
  output logic         sclk,
  output logic         csB,
  output logic         mosi,
  input  wire logic    soOut,
  input  wire logic    soOeN,
  output logic [255:0] rxBits,
  output logic         firstOut,
  output logic [8:0]   drvCnt
);
  // A released output shows the inverse of soOut, so the model
  // never reads a believable level off a floating line
  logic soBus;
  assign soBus = soOeN ? ~soOut : soOut;
  initial begin
    sclk   = 1'b0;
    csB    = 1'b1;
    mosi   = 1'b0;
    rxBits = '0;
    drvCnt = 9'h000;
  end
  // Clock idles low, so both select edges see it low
  task automatic xfer(input int n, input logic [255:0] tx);
    rxBits = '0;
    drvCnt = 9'h000;
    #3.3;
    mosi = (n > 0) ? tx[n-1] : 1'b0;
    csB  = 1'b0;
    #100 firstOut = soBus;
    #100;
    for (int k = 0; k < n; k++) begin
      mosi = tx[n-1-k];
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      rxBits[n-1-k] = soBus;
      if (soOeN === 1'b0) drvCnt++;
      #40;
    end
    #200 csB = 1'b1;
    // Input has a pull-down once the master lets go of it
    mosi = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: bench/spi_slave_frame_checker_tb_top.sv
// Self-checking testbench of the serial slave frame checker
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("Error at %0t: %s", $time, msg); \
  end \
end
module spi_slave_frame_checker_tb_top
  import ssfc_pkg::*;
;
  logic         sys_clk;
  logic         rst_b;
  logic         sleepMode;
  logic [15:0]  respWord;
  ssfc_cmd_t    cmd;
  ssfc_pad_t    serialOut;
  logic         frameErrorFlag;
  logic         frameBusy;
  logic         sclk;
  logic         csB;
  logic         mosi;
  logic [255:0] rxBits;
  logic         firstOut;
  logic [8:0]   drvCnt;
  logic [15:0]  gotWord;
  int           nValid;
  int           n_errors;
  int           cmp_count;

  ssfc_top DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1), .serialClk(sclk),
    .selectActiveLow(csB), .serialIn(mosi), .sleepMode(sleepMode),
    .respWord(respWord), .cmd(cmd), .serialOut(serialOut),
    .frameErrorFlag(frameErrorFlag), .frameBusy(frameBusy)
  );
  ssfc_spi_master m (
    .sclk(sclk), .csB(csB), .mosi(mosi), .soOut(serialOut.out),
    .soOeN(serialOut.oeN), .rxBits(rxBits), .firstOut(firstOut),
    .drvCnt(drvCnt)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      gotWord <= 16'h0000;
      nValid  <= 0;
    end else if (cmd.valid === 1'b1) begin
      gotWord <= cmd.word;
      nValid  <= nValid + 1;
    end
  end

  task automatic report_and_stop;
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One frame through the link, judged against the length rule
  task automatic frame(input int n, input logic [255:0] tx,
                       input logic [15:0] resp);
    logic         pre;
    logic         ok;
    logic         msb;
    logic         busyMid;
    int           v0;
    logic [255:0] expRx;
    @(posedge sys_clk) #1;
    respWord = resp;
    pre = frameErrorFlag;
    ok = (n >= 16) && (n % 8 == 0);
    msb = (n > 0) ? tx[n-1] : 1'b0;
    v0 = nValid;
    `CHK(serialOut.oeN, 1'b1, "output driven while idle")
    // Busy is looked at 300 ns in, while select is still low in every frame
    fork
      m.xfer(n, tx);
      begin
        #300;
        busyMid = frameBusy;
      end
    join
    repeat (10) @(posedge sys_clk);
    #1;
    if (n >= 16) begin
      expRx = (256'(resp) << (n - 16)) | (tx >> 16);
    end else begin
      expRx = 256'(resp) >> (16 - n);
    end
    `CHK(busyMid, 1'b1, "not busy during frame")
    `CHK(frameBusy, 1'b0, "still busy after frame")
    if (sleepMode) begin
      `CHK(drvCnt, 9'h000, "output driven in sleep")
      `CHK(nValid - v0, 0, "command taken in sleep")
      `CHK(frameErrorFlag, pre, "flag moved in sleep")
    end else begin
      `CHK(firstOut, pre | msb, "first output bit")
      `CHK(drvCnt, 9'(n), "output not driven")
      `CHK(rxBits, expRx, "shifted out data")
      `CHK(nValid - v0, ok ? 1 : 0, "command count")
      `CHK(frameErrorFlag, !ok, "error flag")
      if (ok) `CHK(gotWord, tx[15:0], "command word")
    end
  endtask

  task automatic test_single;
    frame(16, 256'hA5C3, 16'h1E96);
    frame(16, 256'h0F0F, 16'hC001);
  endtask

  // Longer frames: bytes after the first sixteen bits pass through
  task automatic test_chain;
    frame(24, 256'hB1C2D3, 16'h7E81);
    frame(32, 256'h12345678, 16'h8001);
  endtask

  task automatic test_bad_and_sleep;
    // No pulses right after a good frame: the old count must not pass
    frame(0, 256'h0, 16'h5AA5);
    frame(8, 256'h5A, 16'h3C3C);
    frame(20, 256'hABCDE, 16'h9669);
    @(posedge sys_clk) #1;
    sleepMode = 1'b1;
    frame(16, 256'h4242, 16'h1111);
    @(posedge sys_clk) #1;
    sleepMode = 1'b0;
    frame(16, 256'h7FFE, 16'h2468);
  endtask

  initial begin
    rst_b     = 1'b0;
    sleepMode = 1'b0;
    respWord  = 16'h0000;
    n_errors  = 0;
    cmp_count = 0;
    repeat (12) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    test_single();
    test_chain();
    test_bad_and_sleep();
    report_and_stop();
  end

  // Nine frames of at most 32 bits need well under 100 us
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
